// ---- hw/mrf_map.svh ----
// Purpose: offsets, fields, resets, timing and characters of the formatter
// Assumes: included by bare name
// Notes:   definitions only
`ifndef MRF_MAP_SVH
`define MRF_MAP_SVH
`define MRF_OFS_CTRL   4'h0
`define MRF_OFS_STATUS 4'h4
`define MRF_OFS_STAMP  4'h8
`define MRF_CTRL_TS    0
`define MRF_CTRL_HDR   1
`define MRF_CTRL_BIN   2
`define MRF_CTRL_MON   3
`define MRF_CTRL_DLM   4
`define MRF_CTRL_CLR   8
`define MRF_CTRL_RST   32'h0000_0002
`define MRF_TS_STEP_MS 10
`define MRF_CLK_KHZ    200000
`define MRF_TICK_CYC   (`MRF_TS_STEP_MS * `MRF_CLK_KHZ)
`define MRF_CH_PLUS    8'h2b
`define MRF_CH_MINUS   8'h2d
`define MRF_CH_DOT     8'h2e
`define MRF_CH_COMMA   8'h2c
`define MRF_CH_SPACE   8'h20
`define MRF_CH_CR      8'h0d
`define MRF_CH_LF      8'h0a
`define MRF_CH_ZERO    8'h30
`define MRF_CH_EXP     8'h45
`define MRF_CODE_VOLT  16'h4456
`define MRF_CODE_CURR  16'h4449
`define MRF_CODE_EMPTY 16'h4545
`define MRF_CODE_MVOLT 16'h5356
`define MRF_CODE_MCURR 16'h5349
`define MRF_STAT_CHARS 80'h5355424f4548474c434e
`define MRF_BCD_OVER   24'h999999
`define MRF_BCD_EMPTY  24'h888888
`define MRF_EXP_OVER   4'h9
`define MRF_EXP_EMPTY  4'h8
`define MRF_EXP_SCALE  4'h2
`define MRF_EXP_TOTAL  4'h1
`endif

// ---- hw/mrf_pkg.sv ----
// Purpose: types of the measurement result formatter
// Assumes: nothing
// Notes:   register state is one packed struct
package mrf_pkg;
   typedef enum logic [3:0] {
      MRF_R_V300M = 4'h0, MRF_R_V3 = 4'h1, MRF_R_V10 = 4'h2,
      MRF_R_V30 = 4'h3, MRF_R_V100 = 4'h4, MRF_R_I3U = 4'h5,
      MRF_R_I30U = 4'h6, MRF_R_I300U = 4'h7, MRF_R_I3M = 4'h8,
      MRF_R_I30M = 4'h9, MRF_R_I300M = 4'ha, MRF_R_I3A = 4'hb,
      MRF_R_I20A = 4'hc
   } mrf_range_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_TS = 4'h1, ST_SDL = 4'h2, ST_HDR = 4'h3,
      ST_MANT = 4'h4, ST_EXP = 4'h5, ST_MSEP = 4'h6, ST_MHDR = 4'h7,
      ST_MMANT = 4'h8, ST_MEXP = 4'h9, ST_TERM = 4'ha, ST_BIN = 4'hb
   } mrf_state_t;
   typedef struct packed {
      mrf_state_t  state;
      logic [3:0]  idx;
      logic [7:0]  data;
      logic        valid, eoi;
      logic        ts_en, hdr_en, bin_en, mon_en;
      logic [1:0]  dlm;
      logic        c_ts, c_hdr, c_bin, c_mon;
      logic [1:0]  c_dlm;
      logic        volt, neg, calc_total, empty;
      mrf_range_t  rng;
      logic [23:0] bcd;
      logic [9:0]  cond;
      logic        mvolt, mneg;
      mrf_range_t  mrng;
      logic [23:0] mbcd;
      logic [63:0] dbl;
      logic [39:0] ts_snap, ts_bcd;
      logic [31:0] ts_bin, tick_cnt;
      logic        tick, ack;
      logic [31:0] rdata;
   } mrf_regs_t;
endpackage

// ---- hw/mrf_formatter.sv ----
// Purpose: formats measurement records as text or binary byte stream
// Assumes: measurement inputs come from logic on mclk
// Notes:   Avalon-MM slave, one wait state per access
// Notes on behaviour
// - time stamp in ms, ten decimal digits, advanced by 10 ms steps
// - time stamp off drops the stamp and its following delimiter
// - stamp wraps at 2^32 ms (~1193 h); software can clear it
// - header off sends no header characters
// - main code is voltage, current or empty-memory code
// - monitor header: monitor code then exactly one blank
// - main code is followed by exactly one status character
// - status character is highest active condition, else a space
// - mantissa is sign, decimal point and six digits
// - exponent is E, sign and one digit
// - voltage ranges fix integer digits and exponent
// - current ranges fix integer digits and exponent per decade
// - over, scaling, total, empty use reserved mantissa/exponent
// - binary mode sends an eight byte double
// - binary bytes go least significant first
// - double uses bias 1023 exponent and 52 bit fraction
// - binary mode covers live and recalled results alike
// - binary mode sends no text elements
// - binary mode ends the block with EOI alone
// - text terminator: CR LF EOI, LF, or EOI alone
//
// The address map and the Avalon-MM slave port were left to the implementer.
`include "mrf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mrf_formatter #(
   parameter int unsigned TICK_CYC = `MRF_TICK_CYC
) (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               meas_valid,
   output logic                    meas_ready,
   input  wire logic               meas_volt,
   input  wire mrf_pkg::mrf_range_t meas_range,
   input  wire logic               meas_neg,
   input  wire logic [23:0]        meas_digits,
   input  wire logic [9:0]         meas_cond,
   input  wire logic               meas_calc_total,
   input  wire logic               meas_empty,
   input  wire logic               mon_volt,
   input  wire mrf_pkg::mrf_range_t mon_range,
   input  wire logic               mon_neg,
   input  wire logic [23:0]        mon_digits,
   input  wire logic [63:0]        meas_double,
   output logic                    out_valid,
   input  wire logic               out_ready,
   output logic [7:0]              out_data,
   output logic                    out_eoi
);
   import mrf_pkg::*;

   if (TICK_CYC < 1) begin : g_tick_chk
      $error("TICK_CYC must be at least one");
   end

   mrf_regs_t q;
   mrf_regs_t next_q;
   logic [7:0] pos;
   logic [7:0] after;
   logic       acc;
   logic       clr;
   logic       bus_go;
   logic [32:0] ts_sum;
   logic       cy;
   logic [7:0] bin_chk;

   // ---------------------------------------------------------------
   // formatting helpers
   // ---------------------------------------------------------------
   // {integer digits, exponent negative, exponent digit}
   function automatic logic [6:0] rng_fmt(mrf_range_t r);
      case (r)
         MRF_R_V300M: rng_fmt = {2'd3, 1'b1, 4'h3};
         MRF_R_V3:    rng_fmt = {2'd1, 1'b0, 4'h0};
         MRF_R_V10:   rng_fmt = {2'd2, 1'b0, 4'h0};
         MRF_R_V30:   rng_fmt = {2'd2, 1'b0, 4'h0};
         MRF_R_V100:  rng_fmt = {2'd3, 1'b0, 4'h0};
         MRF_R_I3U:   rng_fmt = {2'd1, 1'b1, 4'h6};
         MRF_R_I30U:  rng_fmt = {2'd2, 1'b1, 4'h6};
         MRF_R_I300U: rng_fmt = {2'd3, 1'b1, 4'h6};
         MRF_R_I3M:   rng_fmt = {2'd1, 1'b1, 4'h3};
         MRF_R_I30M:  rng_fmt = {2'd2, 1'b1, 4'h3};
         MRF_R_I300M: rng_fmt = {2'd3, 1'b1, 4'h3};
         MRF_R_I3A:   rng_fmt = {2'd1, 1'b0, 4'h0};
         MRF_R_I20A:  rng_fmt = {2'd2, 1'b0, 4'h0};
         default:     rng_fmt = {2'd1, 1'b0, 4'h0};
      endcase
   endfunction

   // {neg, bcd, integer digits, exponent negative, exponent digit}
   function automatic logic [31:0] val_fmt(logic mon, mrf_regs_t s);
      logic [6:0] f;
      f = rng_fmt(mon ? s.mrng : s.rng);
      val_fmt = mon ? {s.mneg, s.mbcd, f} : {s.neg, s.bcd, f};
      if (s.empty) begin
         val_fmt = {1'b0, `MRF_BCD_EMPTY, 2'd3, 1'b0, `MRF_EXP_EMPTY};
      end else if (!mon && s.cond[6]) begin
         val_fmt = {1'b0, `MRF_BCD_OVER, 2'd3, 1'b0, `MRF_EXP_OVER};
      end else if (!mon && s.cond[5]) begin
         val_fmt = {1'b0, `MRF_BCD_OVER, 2'd3, 1'b0,
                    s.calc_total ? `MRF_EXP_TOTAL : `MRF_EXP_SCALE};
      end
   endfunction

   // sign, digits and point placed by the range
   function automatic logic [7:0] mant_ch(logic [3:0] k, logic [31:0] v);
      logic [3:0] d;
      logic [3:0] nint;
      d = 4'h0;
      nint = {2'b00, v[6:5]};
      if (k == 4'h0) begin
         mant_ch = v[31] ? `MRF_CH_MINUS : `MRF_CH_PLUS;
      end else if (k == nint + 4'h1) begin
         mant_ch = `MRF_CH_DOT;
      end else begin
         d = (k <= nint) ? k - 4'h1 : k - 4'h2;
         mant_ch = `MRF_CH_ZERO + {4'h0, v[30 - 4*d -: 4]};
      end
   endfunction

   function automatic logic [7:0] exp_ch(logic [3:0] k, logic [31:0] v);
      case (k)
         4'h0:    exp_ch = `MRF_CH_EXP;
         4'h1:    exp_ch = v[4] ? `MRF_CH_MINUS : `MRF_CH_PLUS;
         default: exp_ch = `MRF_CH_ZERO + {4'h0, v[3:0]};
      endcase
   endfunction

   function automatic logic [7:0] stat_ch(logic [9:0] c);
      stat_ch = `MRF_CH_SPACE;
      for (int i = 0; i < 10; i++) begin
         if (c[i]) begin
            stat_ch = 8'(`MRF_STAT_CHARS >> (8 * i));
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // record walk
   // ---------------------------------------------------------------
   function automatic logic en(mrf_state_t st, mrf_regs_t s);
      case (st)
         ST_TS, ST_SDL:      en = s.c_ts && !s.c_bin;
         ST_HDR:             en = s.c_hdr && !s.c_bin;
         ST_MANT, ST_EXP:    en = !s.c_bin;
         ST_MSEP, ST_MMANT:  en = s.c_mon && !s.c_bin;
         ST_MEXP:            en = s.c_mon && !s.c_bin;
         ST_MHDR:            en = s.c_mon && s.c_hdr && !s.c_bin;
         ST_TERM:            en = s.c_dlm != 2'd2 && !s.c_bin;
         ST_BIN:             en = s.c_bin;
         default:            en = 1'b0;
      endcase
   endfunction

   function automatic logic [3:0] flen(mrf_state_t st);
      case (st)
         ST_TS:              flen = 4'd10;
         ST_HDR, ST_MHDR:    flen = 4'd3;
         ST_MANT, ST_MMANT:  flen = 4'd8;
         ST_EXP, ST_MEXP:    flen = 4'd3;
         ST_TERM:            flen = 4'd2;
         ST_BIN:             flen = 4'd8;
         default:            flen = 4'd1;
      endcase
   endfunction

   // next position {state, idx}; idle when the record is over
   function automatic logic [7:0] nxt_pos(mrf_state_t st, logic [3:0] i,
                                          mrf_regs_t s);
      logic found;
      mrf_state_t k;
      found = 1'b0;
      k = ST_IDLE;
      nxt_pos = {ST_IDLE, 4'h0};
      if (st != ST_IDLE && i + 4'h1 < flen(st)) begin
         nxt_pos = {st, i + 4'h1};
      end else begin
         for (int j = 1; j < 12; j++) begin
            k = mrf_state_t'(j[3:0]);
            if (!found && k > st && en(k, s)) begin
               found = 1'b1;
               nxt_pos = {k, (k == ST_TERM && s.c_dlm == 2'd1) ? 4'h1
                                                             : 4'h0};
            end
         end
      end
   endfunction

   function automatic logic [7:0] char_at(logic [7:0] p, mrf_regs_t s);
      logic [3:0] i;
      logic [15:0] code;
      i = p[3:0];
      code = 16'h0;
      case (mrf_state_t'(p[7:4]))
         ST_TS: char_at = `MRF_CH_ZERO + {4'h0, s.ts_snap[39 - 4*i -: 4]};
         ST_SDL, ST_MSEP: char_at = `MRF_CH_COMMA;
         ST_HDR: begin
            code = s.empty ? `MRF_CODE_EMPTY : s.volt ? `MRF_CODE_VOLT
                                                      : `MRF_CODE_CURR;
            char_at = (i == 4'h0) ? code[15:8] : (i == 4'h1) ? code[7:0]
                                                : stat_ch(s.cond);
         end
         ST_MHDR: begin
            code = s.empty ? `MRF_CODE_EMPTY : s.mvolt ? `MRF_CODE_MVOLT
                                                       : `MRF_CODE_MCURR;
            char_at = (i == 4'h0) ? code[15:8] : (i == 4'h1) ? code[7:0]
                                                : `MRF_CH_SPACE;
         end
         ST_MANT:  char_at = mant_ch(i, val_fmt(1'b0, s));
         ST_EXP:   char_at = exp_ch(i, val_fmt(1'b0, s));
         ST_MMANT: char_at = mant_ch(i, val_fmt(1'b1, s));
         ST_MEXP:  char_at = exp_ch(i, val_fmt(1'b1, s));
         ST_TERM:  char_at = (i == 4'h0) ? `MRF_CH_CR : `MRF_CH_LF;
         ST_BIN:   char_at = s.dbl[{i[2:0], 3'b000} +: 8];
         default:  char_at = 8'h00;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   assign acc = q.valid && out_ready;
   assign bus_go = (avs_read || avs_write) && !q.ack;
   assign clr = avs_write && q.ack && avs_address == `MRF_OFS_CTRL
                && avs_byteenable[1] && avs_writedata[`MRF_CTRL_CLR];
   assign ts_sum = {1'b0, q.ts_bin} + 33'(`MRF_TS_STEP_MS);
   assign cy = ts_sum[32];

   always_comb begin
      next_q = q;
      pos = {ST_IDLE, 4'h0};
      after = {ST_IDLE, 4'h0};
      // 10 ms tick from the clock divider
      next_q.tick = 1'b0;
      next_q.tick_cnt = q.tick_cnt + 32'h1;
      if (q.tick_cnt >= TICK_CYC - 1) begin
         next_q.tick_cnt = 32'h0;
         next_q.tick = 1'b1;
      end
      if (q.tick) begin
         // binary carry out of 32 bits is the wrap point
         next_q.ts_bin = ts_sum[31:0];
         for (int d = 1; d < 10; d++) begin
            if (d == 1 || next_q.ts_bcd[4*d-1 -: 4] == 4'h0) begin
               if (d == 1 || q.ts_bcd[4*d-1 -: 4] == 4'h9) begin
                  next_q.ts_bcd[4*d +: 4] = (q.ts_bcd[4*d +: 4] == 4'h9)
                     ? 4'h0 : q.ts_bcd[4*d +: 4] + 4'h1;
               end
            end
         end
         if (cy) begin
            next_q.ts_bin = 32'h0;
            next_q.ts_bcd = 40'h0;
         end
      end
      if (clr) begin
         next_q.ts_bin = 32'h0;
         next_q.ts_bcd = 40'h0;
      end
      // register bus
      next_q.ack = bus_go;
      if (bus_go) begin
         case (avs_address)
            `MRF_OFS_CTRL: next_q.rdata = {26'h0, q.dlm, q.mon_en,
                                           q.bin_en, q.hdr_en, q.ts_en};
            `MRF_OFS_STATUS: next_q.rdata = {30'h0, q.valid,
                                             q.state != ST_IDLE};
            `MRF_OFS_STAMP: next_q.rdata = q.ts_bin;
            default: next_q.rdata = 32'h0;
         endcase
      end
      if (avs_write && q.ack && avs_address == `MRF_OFS_CTRL
          && avs_byteenable[0]) begin
         next_q.ts_en = avs_writedata[`MRF_CTRL_TS];
         next_q.hdr_en = avs_writedata[`MRF_CTRL_HDR];
         next_q.bin_en = avs_writedata[`MRF_CTRL_BIN];
         next_q.mon_en = avs_writedata[`MRF_CTRL_MON];
         next_q.dlm = avs_writedata[`MRF_CTRL_DLM +: 2];
      end
      // record emission
      if (q.state == ST_IDLE) begin
         if (meas_valid) begin
            next_q.c_ts = q.ts_en;
            next_q.c_hdr = q.hdr_en;
            next_q.c_bin = q.bin_en;
            next_q.c_mon = q.mon_en;
            next_q.c_dlm = q.dlm;
            next_q.volt = meas_volt;
            next_q.rng = meas_range;
            next_q.neg = meas_neg;
            next_q.bcd = meas_digits;
            next_q.cond = meas_cond;
            next_q.calc_total = meas_calc_total;
            next_q.empty = meas_empty;
            next_q.mvolt = mon_volt;
            next_q.mrng = mon_range;
            next_q.mneg = mon_neg;
            next_q.mbcd = mon_digits;
            next_q.dbl = meas_double;
            next_q.ts_snap = q.ts_bcd;
            pos = nxt_pos(ST_IDLE, 4'h0, next_q);
         end
      end else if (acc) begin
         pos = nxt_pos(q.state, q.idx, q);
         if (pos[7:4] == ST_IDLE) begin
            next_q.valid = 1'b0;
            next_q.eoi = 1'b0;
            next_q.state = ST_IDLE;
            next_q.idx = 4'h0;
         end
      end
      if (pos[7:4] != ST_IDLE) begin
         after = nxt_pos(mrf_state_t'(pos[7:4]), pos[3:0], next_q);
         next_q.state = mrf_state_t'(pos[7:4]);
         next_q.idx = pos[3:0];
         next_q.data = char_at(pos, next_q);
         next_q.valid = 1'b1;
         // EOI on the last byte unless LF alone was chosen in text mode
         next_q.eoi = after[7:4] == ST_IDLE
                      && (next_q.c_bin || next_q.c_dlm != 2'd1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
         {q.dlm, q.mon_en, q.bin_en, q.hdr_en, q.ts_en} <= 6'(`MRF_CTRL_RST);
      end else begin
         q <= next_q;
      end
   end

   assign avs_readdata = q.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
   assign meas_ready = q.state == ST_IDLE;
   assign out_valid = q.valid;
   assign out_data = q.data;
   assign out_eoi = q.eoi;
   assign bin_chk = q.dbl[{q.idx[2:0], 3'b000} +: 8];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_exp_start;
      out_valid && q.state == ST_EXP && q.idx == 4'h0;
   endsequence
   sequence s_mant_end;
      out_valid && out_ready && q.state == ST_MANT && q.idx == 4'h7;
   endsequence

   ts_step_a: assert property (q.tick && !clr |=>
      q.ts_bin == $past(q.ts_bin) + 32'd10 || q.ts_bin == 32'h0)
      else $error("time stamp did not step by 10 ms");
   ts_omit_a: assert property (out_valid &&
      (q.state == ST_TS || q.state == ST_SDL) |-> q.c_ts)
      else $error("time stamp sent while disabled");
   ts_clear_a: assert property (clr |=> q.ts_bin == 32'h0
      && q.ts_bcd == 40'h0) else $error("time stamp not cleared");
   hdr_omit_a: assert property (out_valid &&
      (q.state == ST_HDR || q.state == ST_MHDR) |-> q.c_hdr)
      else $error("header sent while disabled");
   empty_code_a: assert property (out_valid && q.state == ST_HDR
      && q.idx == 4'h1 && q.empty |-> out_data == `MRF_CH_EXP)
      else $error("empty memory code wrong");
   mon_blank_a: assert property (out_valid && q.state == ST_MHDR
      && q.idx == 4'h2 |-> out_data == `MRF_CH_SPACE)
      else $error("monitor blank missing");
   stat_osc_a: assert property (out_valid && q.state == ST_HDR
      && q.idx == 4'h2 && q.cond[9] |-> out_data == 8'h53)
      else $error("status priority wrong");
   mant_dp_a: assert property (out_valid && q.state == ST_MANT
      && q.idx == 4'h2 && q.rng == MRF_R_V3 && q.cond[6:5] == 2'b00
      && !q.empty |-> out_data == `MRF_CH_DOT)
      else $error("decimal point misplaced");
   exp_lead_a: assert property (s_exp_start |->
      out_data == `MRF_CH_EXP) else $error("exponent lead wrong");
   exp_step_a: assert property (s_exp_start ##0 out_ready |=>
      q.idx == 4'h1 && q.state == ST_EXP)
      else $error("exponent sign step wrong");
   over_val_a: assert property (out_valid && q.state == ST_EXP
      && q.idx == 4'h2 && q.cond[6] && !q.empty |-> out_data == 8'h39)
      else $error("range over exponent wrong");
   bin_order_a: assert property (out_valid && q.state == ST_BIN
      |-> out_data == bin_chk) else $error("binary byte order wrong");
   bin_eoi_a: assert property (out_valid && q.c_bin |->
      out_eoi == (q.idx == 4'h7)) else $error("binary EOI wrong");
   term_lf_a: assert property (out_valid && q.state == ST_TERM
      && q.idx == 4'h1 |-> out_data == `MRF_CH_LF
      && out_eoi == (q.c_dlm != 2'd1)) else $error("terminator wrong");
   field_order_a: assert property (s_mant_end |=>
      q.state == ST_EXP && q.idx == 4'h0) else $error("field order wrong");
endmodule // mrf_formatter
`default_nettype wire

// ---- bench/mrf_reader.sv ----
// Purpose: remote controller taking formatter bytes
// Assumes: single mclk domain
// Notes:   stalls at random while slow is high
`timescale 1ns/1ps
`default_nettype none
module mrf_reader (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic slow,
   output logic      out_ready
);
   always @(posedge mclk) begin
      if (rst)
         out_ready <= 1'b0;
      else
         out_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
   end
endmodule // mrf_reader
`default_nettype wire

// ---- bench/measurement_result_formatter_tb_top.sv ----
// Purpose: self-checking bench of the result formatter
// Assumes: reader model supplies out_ready
// Notes:   driver queues expected bytes, monitor pops them
`include "mrf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module measurement_result_formatter_tb_top;
   import mrf_pkg::*;
   localparam int TICK = 10;
   localparam logic [25:0] KT = 26'b10_01_11_10_01_11_10_01_11_10_10_01_11;
   logic        mclk = 0, rst = 1, slow = 0, avs_read = 0, avs_write = 0;
   logic [3:0]  avs_address = 0, avs_byteenable = 4'h1;
   logic [31:0] avs_writedata = 0, avs_readdata, q;
   logic        avs_waitrequest, meas_ready, out_valid, out_ready, out_eoi;
   logic [7:0]  out_data;
   logic        meas_valid = 0, meas_volt = 0, meas_neg = 0, meas_empty = 0;
   logic        meas_calc_total = 0, mon_volt = 0, mon_neg = 0;
   mrf_range_t  meas_range = MRF_R_V3, mon_range = MRF_R_V3;
   logic [23:0] meas_digits = 0, mon_digits = 0, dig, mdig;
   logic [9:0]  meas_cond = 0, cond, e;
   logic [63:0] meas_double = 0, dbl;
   logic        volt, neg, total, empty, mvolt, mneg, ts, hdr, bin, mon;
   logic [3:0]  rng, mrng;
   logic [1:0]  dlm;
   logic [9:0]  exp_q[$];
   int          n_fail = 0, compares = 0, cyc = 0;
   always #2.5 mclk = ~mclk;
   mrf_formatter #(.TICK_CYC(TICK)) mrf_formatter_i (.mclk, .rst,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .meas_valid, .meas_ready, .meas_volt,
      .meas_range, .meas_neg, .meas_digits, .meas_cond, .meas_calc_total,
      .meas_empty, .mon_volt, .mon_range, .mon_neg, .mon_digits,
      .meas_double, .out_valid, .out_ready, .out_data, .out_eoi);
   mrf_reader mrf_reader_i (.mclk, .rst, .slow, .out_ready);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string s, input logic [31:0] seen, x);
      compares++;
      if (seen !== x) begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", s, x, seen);
      end
   endtask
   task automatic summarize();
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, be,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic cfg();
      bus(1, `MRF_OFS_CTRL, 4'h1, {26'h0, dlm, mon, bin, hdr, ts}, q);
   endtask
   function automatic logic [23:0] rbcd();
      for (int j = 0; j < 6; j++) rbcd[4*j +: 4] = 4'($urandom_range(9));
   endfunction
   function automatic logic [7:0] stc(input logic [9:0] c);
      stc = " ";
      for (int i = 0; i < 10; i++) if (c[i]) stc = 8'(`MRF_STAT_CHARS >> 8*i);
   endfunction
   task automatic put(input logic [7:0] c, input logic eo = 0, any = 0);
      exp_q.push_back({any, eo, c});
   endtask
   task automatic put_val(input logic [3:0] r, input logic n,
                          input logic [23:0] d, input logic [3:0] sx);
      int k, x;
      k = sx != 0 ? 3 : int'(KT[2*r +: 2]);
      x = (r == 0 || (r > 7 && r < 11)) ? 3 : (r > 4 && r < 8) ? 6 : 0;
      put(n && sx == 0 ? "-" : "+");
      for (int j = 0; j < 6; j++) begin
         if (j == k) put(".");
         put(8'h30 + 8'(d[23-4*j -: 4]));
      end
      put("E");
      put(x != 0 && sx == 0 ? "-" : "+");
      put(8'h30 + 8'(sx != 0 ? sx : 4'(x)));
   endtask
   task automatic rec();
      logic [3:0] sx;
      if (bin) begin
         for (int i = 0; i < 8; i++) put(dbl[8*i +: 8], i == 7);
      end else begin
         if (ts) begin
            repeat (10) put("0", 0, 1);
            put(",");
         end
         if (hdr) begin
            put(empty ? "E" : "D");
            put(empty ? "E" : volt ? "V" : "I");
            put(stc(cond));
         end
         sx = empty ? 4'h8 : cond[6] ? 4'h9 : cond[5] ? (total ? 4'h1 : 4'h2) : 4'h0;
         put_val(rng, neg, sx == 8 ? 24'h888888 : sx != 0 ? 24'h999999 : dig, sx);
         if (mon) begin
            put(",");
            if (hdr) begin
               put(empty ? "E" : "S");
               put(empty ? "E" : mvolt ? "V" : "I");
               put(" ");
            end
            put_val(mrng, mneg, empty ? 24'h888888 : mdig, empty ? 4'h8 : 4'h0);
         end
         if (dlm == 2) exp_q[exp_q.size()-1][8] = 1'b1;
         else begin
            if (dlm != 1) put(8'h0d);
            put(8'h0a, dlm != 1);
         end
      end
      @(posedge mclk);
      {meas_volt, meas_neg, meas_digits, meas_cond, meas_calc_total, meas_empty,
       mon_volt, mon_neg, mon_digits, meas_double} <=
         {volt, neg, dig, cond, total, empty, mvolt, mneg, mdig, dbl};
      meas_range <= mrf_range_t'(rng);
      mon_range <= mrf_range_t'(mrng);
      meas_valid <= 1'b1;
      do @(posedge mclk); while (meas_ready !== 1'b1);
      meas_valid <= 1'b0;
   endtask
   // ----------------------------------------
   // monitor, timeout, main sequence
   // ----------------------------------------
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         summarize();
      end
      if (!rst && out_valid === 1'b1 && out_ready) begin
         if (exp_q.size() == 0) check("extra byte", {out_eoi, out_data}, 0);
         else begin
            e = exp_q.pop_front();
            if (e[9]) check("stamp digit", 32'(out_data inside {[8'h30:8'h39]}), 1);
            else check("byte", {out_eoi, out_data}, e[8:0]);
         end
      end
   end
   initial begin
      q = $urandom(32'h7437a1d4);
      {ts, bin, mon, dlm, empty, cond, total, neg, mvolt, mneg, mrng} = '0;
      {hdr, volt, rng, dig, mdig, dbl} = {1'b1, 1'b1, 4'h1, 24'h123456, 88'h0};
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      bus(0, `MRF_OFS_CTRL, 4'h1, 0, q);
      check("ctrl", q, `MRF_CTRL_RST);
      bus(1, 4'hc, 4'hf, 32'hffffffff, q);
      bus(0, 4'hc, 4'hf, 0, q);
      check("unmapped", q, 0);
      cfg();
      rec();
      slow <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         rng = 4'(i);
         volt = i < 5;
         neg = 1'($urandom);
         dig = rbcd();
         mrng = 4'($urandom_range(12));
         mvolt = mrng < 5;
         mneg = 1'($urandom);
         mdig = rbcd();
         {mon, hdr, dlm} = {1'b1, 1'($urandom), 2'(i)};
         cfg();
         rec();
      end
      hdr = 1;
      cfg();
      for (int i = 0; i < 10; i++) begin
         cond = 10'(1 << i) | (10'($urandom) & 10'((1 << i) - 1) & 10'h39f);
         total = 1'($urandom);
         rec();
      end
      cond = 0;
      empty = 1;
      rec();
      {bin, ts, dlm, dbl} = {2'b11, 2'h1, 32'($urandom), 32'($urandom)};
      cfg();
      rec();
      empty = 0;
      rec();
      {bin, mon} = 2'b00;
      cfg();
      rec();
      bus(1, `MRF_OFS_CTRL, 4'h3, 32'h100 | {26'h0, dlm, mon, bin, hdr, ts}, q);
      repeat (200) @(posedge mclk);
      bus(0, `MRF_OFS_STAMP, 4'h1, 0, q);
      check("stamp", 32'(q >= 190 && q <= 220), 1);
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge mclk);
      check("left", 32'(exp_q.size()), 0);
      summarize();
   end
endmodule // measurement_result_formatter_tb_top
`default_nettype wire
